// ### mtp_defines.vh
// Constants for the motor thermal protection block
`ifndef MTP_DEFINES_VH
`define MTP_DEFINES_VH
`define MTP_CLK_NS 10
`define MTP_MS_NS 1000000
`define MTP_OFS_RATED 5'h00
`define MTP_OFS_CFG 5'h04
`define MTP_OFS_TIME 5'h08
`define MTP_OFS_TEMP 5'h0c
`define MTP_OFS_STATUS 5'h10
`define MTP_OFS_IRQ_STAT 5'h14
`define MTP_OFS_IRQ_MASK 5'h18
`define MTP_OFS_FAULT_CLR 5'h1c
`define MTP_CFG_PROT_LSB 0
`define MTP_CFG_OHA_LSB 2
`define MTP_CFG_OHF_LSB 4
`define MTP_CFG_REV_LSB 6
`define MTP_CFG_AIFN_LSB 8
`define MTP_CFG_AILVL_BIT 13
`define MTP_CFG_RLYA_LSB 16
`define MTP_CFG_RLYB_LSB 24
`define MTP_TIME_FILT_LSB 16
`define MTP_TEMP_FAULT_LSB 16
`define MTP_RATED_RST 32'h000003e8
`define MTP_CFG_RST 32'h0000001d
`define MTP_TIME_RST 32'h0014000a
`define MTP_TEMP_RST 32'h0a000800
`define MTP_RATED_MIN_PCT 10
`define MTP_RATED_MAX_PCT 200
`define MTP_PCT_FULL 100
`define MTP_OLTC_MIN 16'h0001
`define MTP_OLTC_MAX 16'h0032
`define MTP_FILT_MAX 16'h03e8
`define MTP_MS_PER_OLTC 16'h007f
`define MTP_OL_SHIFT 8
`define MTP_FILT_SHIFT 3
`define MTP_DETECT_NUM 9'h136
`define MTP_ALARM_NUM 40'h9
`define MTP_ALARM_DEN 40'ha
`define MTP_DER0 9'h1ae
`define MTP_DER1 9'h1ae
`define MTP_DER2 9'h16a
`define MTP_DER3 9'h147
`define MTP_DER4 9'h130
`define MTP_DER5 9'h11f
`define MTP_DER6 9'h113
`define MTP_DER7 9'h108
`define MTP_DER_ONE 9'h100
`define MTP_PROT_OFF 2'h0
`define MTP_PROT_SELF 2'h1
`define MTP_FN_PREALARM 8'h1f
`define MTP_AI_MOTOR_TEMP 5'h0e
`define MTP_OHA_CONTINUE 2'h3
`define MTP_STOP_COAST 2'h1
`define MTP_IRQ_OVL 0
`define MTP_IRQ_PRE 1
`define MTP_IRQ_OHA 2
`define MTP_IRQ_OHF 3
`define MTP_RESP_OKAY 2'h0
`define MTP_RESP_SLVERR 2'h2
`endif

// ### mtp_sync.v
// Three-flop input synchroniser with agreement filter
`default_nettype none
module mtp_sync #(
    parameter WIDTH = 1
) (
    input wire clock,
    input wire rst_n,
    input wire ce,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] q1;
    reg [WIDTH-1:0] q2;
    reg [WIDTH-1:0] q3;
    integer i;

    always @(posedge clock) begin
        if (!rst_n) begin
            q1 <= {WIDTH{1'b0}};
            q2 <= {WIDTH{1'b0}};
            q3 <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else if (ce) begin
            q1 <= din;
            q2 <= q1;
            q3 <= q2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (q2[i] == q3[i]) begin
                    dout[i] <= q3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### mtp_lpf.v
// First-order low-pass filter for the motor temperature input
`default_nettype none
`include "mtp_defines.vh"
module mtp_lpf #(
    parameter W = 12
) (
    input wire clock,
    input wire rst_n,
    input wire ce,
    input wire msTick,
    input wire [15:0] tcSetting,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    localparam AW = W + `MTP_FILT_SHIFT;
    reg [AW-1:0] acc;
    reg [17:0] stepCnt;
    wire [15:0] tc = (tcSetting > `MTP_FILT_MAX) ? `MTP_FILT_MAX : tcSetting;
    // Step every 1.25*tc ms; with a 1/8 step the time constant is tc*10 ms
    wire stepDue = ({stepCnt, 2'b00} >= ({4'h0, tc} * 20'h5));
    wire [AW-1:0] nextAcc = acc + {{`MTP_FILT_SHIFT{1'b0}}, din}
        - {{`MTP_FILT_SHIFT{1'b0}}, acc[AW-1:`MTP_FILT_SHIFT]};

    always @(posedge clock) begin
        if (!rst_n) begin
            acc <= {AW{1'b0}};
            stepCnt <= 18'h0;
            dout <= {W{1'b0}};
        end else if (ce) begin
            if (tc == 16'h0) begin
                acc <= {din, {`MTP_FILT_SHIFT{1'b0}}};
                dout <= din;
                stepCnt <= 18'h0;
            end else if (msTick) begin
                if (stepDue) begin
                    stepCnt <= 18'h1;
                    acc <= nextAcc;
                    dout <= nextAcc[AW-1:`MTP_FILT_SHIFT];
                end else begin
                    stepCnt <= stepCnt + 18'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### mtp_top.v
// Motor thermal protection: overload integrator, overheat, direction gate
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
`include "mtp_defines.vh"
module mtp_top #(
    parameter MS_CYCLES = `MTP_MS_NS / `MTP_CLK_NS,
    parameter [15:0] DRIVE_RATED_CURRENT = 16'd1000,
    parameter [15:0] BASE_FREQ = 16'd5000,
    parameter AI_W = 12
) (
    input wire clock,
    input wire rst_n,
    input wire ce,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] outputCurrent,
    input wire [15:0] outputFreq,
    input wire [AI_W-1:0] analogInputTwo,
    input wire fwdRunPin,
    input wire revRunPin,
    output reg runFwd,
    output reg runRev,
    output reg phaseSwap,
    output reg stopCmd,
    output reg [1:0] stopMode,
    output reg relayContactA,
    output reg relayContactB,
    output reg faultRelay,
    output reg motorOverheatAlarm,
    output reg irq
);
    localparam [15:0] RATED_LO = (DRIVE_RATED_CURRENT * `MTP_RATED_MIN_PCT) / `MTP_PCT_FULL;
    localparam [15:0] RATED_HI = (DRIVE_RATED_CURRENT * `MTP_RATED_MAX_PCT) / `MTP_PCT_FULL;

    reg [31:0] ratedReg;
    reg [31:0] cfgReg;
    reg [31:0] timeReg;
    reg [31:0] tempReg;
    reg [3:0] irqStatus;
    reg [3:0] irqMask;
    reg faultClr;
    reg awHeld;
    reg wHeld;
    reg [4:0] awAddrQ;
    reg [31:0] wDataQ;
    reg [3:0] wStrbQ;
    reg [16:0] msCnt;
    reg msTick;
    reg [15:0] olCnt;
    reg [33:0] theta;
    reg motorOverloadFault;
    reg motorOverheatFault;
    reg preAlarm;
    reg ohAlarm;
    reg [3:0] derIdx;
    reg [8:0] derate;
    reg [31:0] rdMux;
    reg rdOk;
    integer k;

    wire [1:0] overloadProtectSelect = cfgReg[`MTP_CFG_PROT_LSB +: 2];
    wire [1:0] overheatAlarmAction = cfgReg[`MTP_CFG_OHA_LSB +: 2];
    wire [1:0] overheatFaultAction = cfgReg[`MTP_CFG_OHF_LSB +: 2];
    wire [1:0] reverseProhibitSelect = cfgReg[`MTP_CFG_REV_LSB +: 2];
    wire [4:0] analogInTwoFunction = cfgReg[`MTP_CFG_AIFN_LSB +: 5];
    wire [7:0] relayOutputAFunction = cfgReg[`MTP_CFG_RLYA_LSB +: 8];
    wire [7:0] relayOutputBFunction = cfgReg[`MTP_CFG_RLYB_LSB +: 8];
    wire [15:0] olTcRaw = timeReg[15:0];
    wire [15:0] tempFilterTc = timeReg[`MTP_TIME_FILT_LSB +: 16];
    wire [15:0] ohAlarmLevel = tempReg[15:0];
    wire [15:0] ohFaultLevel = tempReg[`MTP_TEMP_FAULT_LSB +: 16];

    // Bus handshakes
    wire awGo = s_axi_awvalid & s_axi_awready;
    wire wGo = s_axi_wvalid & s_axi_wready;
    wire arGo = s_axi_arvalid & s_axi_arready;
    wire doWrite = awHeld & wHeld & ~s_axi_bvalid;
    wire next_awHeld = (awHeld | awGo) & ~doWrite;
    wire next_wHeld = (wHeld | wGo) & ~doWrite;
    wire next_bvalid = doWrite | (s_axi_bvalid & ~s_axi_bready);
    wire next_rvalid = arGo | (s_axi_rvalid & ~s_axi_rready);
    wire wrMapped = (awAddrQ[4:2] <= `MTP_OFS_FAULT_CLR >> 2) && (awAddrQ[1:0] == 2'b00);
    wire [31:0] strbMask = {{8{wStrbQ[3]}}, {8{wStrbQ[2]}}, {8{wStrbQ[1]}}, {8{wStrbQ[0]}}};
    wire [31:0] wBits = wDataQ & strbMask;

    // Base current and detection level
    wire [15:0] ratedSet = ratedReg[15:0];
    wire [15:0] ratedCur = (ratedSet < RATED_LO) ? RATED_LO :
        (ratedSet > RATED_HI) ? RATED_HI : ratedSet;
    wire [31:0] ratedSq = ratedCur * ratedCur;
    wire [40:0] detectFull = ratedSq * `MTP_DETECT_NUM;
    wire [33:0] detectLevel = {1'b0, detectFull[40:8]};
    wire [15:0] olTc = (olTcRaw < `MTP_OLTC_MIN) ? `MTP_OLTC_MIN :
        (olTcRaw > `MTP_OLTC_MAX) ? `MTP_OLTC_MAX : olTcRaw;
    wire [31:0] olPeriodFull = olTc * `MTP_MS_PER_OLTC;
    wire [15:0] olPeriod = olPeriodFull[15:0];
    wire protOn = (overloadProtectSelect != `MTP_PROT_OFF);

    // Heating term: squared current, scaled up when self-cooling weakens
    wire [31:0] curSq = outputCurrent * outputCurrent;
    wire [40:0] heatFull = curSq * derate;
    wire [33:0] heat = {1'b0, heatFull[40:8]};
    wire [34:0] diff = {1'b0, heat} - {1'b0, theta};
    wire [34:0] diffStep = {{`MTP_OL_SHIFT{diff[34]}}, diff[34:`MTP_OL_SHIFT]};
    wire [34:0] thetaSum = {1'b0, theta} + diffStep;
    wire [39:0] thetaScaled = {6'h0, theta} * `MTP_ALARM_DEN;
    wire [39:0] detectScaled = {6'h0, detectLevel} * `MTP_ALARM_NUM;
    wire next_preAlarm = protOn & (thetaScaled >= detectScaled);
    wire ovlTrip = protOn & (theta >= detectLevel);

    // Temperature path
    wire [AI_W-1:0] tempFilt;
    wire tempSel = (analogInTwoFunction == `MTP_AI_MOTOR_TEMP);
    wire next_ohAlarm = tempSel & ({{(16-AI_W){1'b0}}, tempFilt} >= ohAlarmLevel);
    wire ohTrip = tempSel & ({{(16-AI_W){1'b0}}, tempFilt} >= ohFaultLevel);

    wire [1:0] runSync;
    wire next_ovlFault = (motorOverloadFault | ovlTrip) & ~(faultClr & ~ovlTrip);
    wire next_ohFault = (motorOverheatFault | ohTrip) & ~(faultClr & ~ohTrip);
    wire next_fault = next_ovlFault | next_ohFault;
    wire alarmStops = next_ohAlarm & (overheatAlarmAction != `MTP_OHA_CONTINUE);
    wire next_stop = next_fault | alarmStops;
    wire revBlock = reverseProhibitSelect[0];
    wire [3:0] irqEvents = {ohTrip & ~motorOverheatFault, next_ohAlarm & ~ohAlarm,
        next_preAlarm & ~preAlarm, ovlTrip & ~motorOverloadFault};
    wire [3:0] irqClr = (doWrite && awAddrQ == `MTP_OFS_IRQ_STAT) ? wBits[3:0] : 4'h0;
    wire [3:0] next_irqStatus = (irqStatus & ~irqClr) | irqEvents;

    mtp_sync #(
        .WIDTH(2)
    ) uRunSync (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .din({revRunPin, fwdRunPin}),
        .dout(runSync)
    );

    mtp_lpf #(
        .W(AI_W)
    ) uTempFilter (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .msTick(msTick),
        .tcSetting(tempFilterTc),
        .din(analogInputTwo),
        .dout(tempFilt)
    );

    // Cooling derate index: eighths of base frequency reached
    always @* begin
        derIdx = 4'h0;
        for (k = 1; k <= 8; k = k + 1) begin
            if ({13'h0, outputFreq, 3'b000} >= k * BASE_FREQ) begin
                derIdx = k[3:0];
            end
        end
        if (overloadProtectSelect != `MTP_PROT_SELF) begin
            derate = `MTP_DER_ONE;
        end else begin
            case (derIdx)
                4'h0: derate = `MTP_DER0;
                4'h1: derate = `MTP_DER1;
                4'h2: derate = `MTP_DER2;
                4'h3: derate = `MTP_DER3;
                4'h4: derate = `MTP_DER4;
                4'h5: derate = `MTP_DER5;
                4'h6: derate = `MTP_DER6;
                4'h7: derate = `MTP_DER7;
                default: derate = `MTP_DER_ONE;
            endcase
        end
    end

    always @* begin
        rdOk = 1'b1;
        case (s_axi_araddr)
            `MTP_OFS_RATED: rdMux = {16'h0, ratedSet};
            `MTP_OFS_CFG: rdMux = cfgReg;
            `MTP_OFS_TIME: rdMux = timeReg;
            `MTP_OFS_TEMP: rdMux = tempReg;
            `MTP_OFS_STATUS: rdMux = {theta[33:18], 9'h0, runRev, runFwd, phaseSwap,
                motorOverheatFault, ohAlarm, preAlarm, motorOverloadFault};
            `MTP_OFS_IRQ_STAT: rdMux = {28'h0, irqStatus};
            `MTP_OFS_IRQ_MASK: rdMux = {28'h0, irqMask};
            `MTP_OFS_FAULT_CLR: rdMux = 32'h0;
            default: begin
                rdMux = 32'h0;
                rdOk = 1'b0;
            end
        endcase
    end

    // Bus slave and registers
    always @(posedge clock) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MTP_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `MTP_RESP_OKAY;
            s_axi_rdata <= 32'h0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= 5'h0;
            wDataQ <= 32'h0;
            wStrbQ <= 4'h0;
            ratedReg <= `MTP_RATED_RST;
            cfgReg <= `MTP_CFG_RST;
            timeReg <= `MTP_TIME_RST;
            tempReg <= `MTP_TEMP_RST;
            irqMask <= 4'h0;
            faultClr <= 1'b0;
        end else if (ce) begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            s_axi_awready <= ~next_awHeld & ~next_bvalid;
            s_axi_wready <= ~next_wHeld & ~next_bvalid;
            s_axi_bvalid <= next_bvalid;
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
            faultClr <= 1'b0;
            if (awGo) begin
                awAddrQ <= s_axi_awaddr;
            end
            if (wGo) begin
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (arGo) begin
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdOk ? `MTP_RESP_OKAY : `MTP_RESP_SLVERR;
            end
            if (doWrite) begin
                s_axi_bresp <= wrMapped ? `MTP_RESP_OKAY : `MTP_RESP_SLVERR;
                case (awAddrQ)
                    `MTP_OFS_RATED: ratedReg <= (ratedReg & ~strbMask) | {16'h0, wBits[15:0]};
                    `MTP_OFS_CFG: cfgReg <= (cfgReg & ~strbMask) | wBits;
                    `MTP_OFS_TIME: timeReg <= (timeReg & ~strbMask) | wBits;
                    `MTP_OFS_TEMP: tempReg <= (tempReg & ~strbMask) | wBits;
                    `MTP_OFS_IRQ_MASK: irqMask <= (irqMask & ~strbMask[3:0]) | wBits[3:0];
                    `MTP_OFS_FAULT_CLR: faultClr <= wBits[0];
                    default: faultClr <= 1'b0;
                endcase
            end
        end
    end

    // Protection state and outputs
    always @(posedge clock) begin
        if (!rst_n) begin
            msCnt <= 17'h0;
            msTick <= 1'b0;
            olCnt <= 16'h0;
            theta <= 34'h0;
            motorOverloadFault <= 1'b0;
            motorOverheatFault <= 1'b0;
            preAlarm <= 1'b0;
            ohAlarm <= 1'b0;
            irqStatus <= 4'h0;
            irq <= 1'b0;
            runFwd <= 1'b0;
            runRev <= 1'b0;
            phaseSwap <= 1'b0;
            stopCmd <= 1'b0;
            stopMode <= 2'h0;
            relayContactA <= 1'b0;
            relayContactB <= 1'b0;
            faultRelay <= 1'b0;
            motorOverheatAlarm <= 1'b0;
        end else if (ce) begin
            msTick <= (msCnt == MS_CYCLES - 1);
            msCnt <= (msCnt == MS_CYCLES - 1) ? 17'h0 : msCnt + 17'h1;
            if (!protOn) begin
                theta <= 34'h0;
                olCnt <= 16'h0;
            end else if (msTick) begin
                if (olCnt + 16'h1 >= olPeriod) begin
                    olCnt <= 16'h0;
                    theta <= thetaSum[33:0];
                end else begin
                    olCnt <= olCnt + 16'h1;
                end
            end
            motorOverloadFault <= next_ovlFault;
            motorOverheatFault <= next_ohFault;
            preAlarm <= next_preAlarm;
            ohAlarm <= next_ohAlarm;
            motorOverheatAlarm <= next_ohAlarm;
            faultRelay <= next_fault;
            relayContactA <= (relayOutputAFunction == `MTP_FN_PREALARM)
                & next_preAlarm & ~next_fault;
            relayContactB <= (relayOutputBFunction == `MTP_FN_PREALARM)
                & next_preAlarm & ~next_fault;
            irqStatus <= next_irqStatus;
            irq <= |(next_irqStatus & irqMask);
            stopCmd <= next_stop;
            if (next_ovlFault) begin
                stopMode <= `MTP_STOP_COAST;
            end else if (next_ohFault) begin
                stopMode <= overheatFaultAction;
            end else begin
                stopMode <= overheatAlarmAction;
            end
            runFwd <= runSync[0] & ~next_stop;
            runRev <= runSync[1] & ~runSync[0] & ~revBlock & ~next_stop;
            phaseSwap <= reverseProhibitSelect[1];
        end
    end
endmodule
`default_nettype wire

// ### mtp_top_props.sv
// Port-level concurrent checks for the motor protection block
`default_nettype none
module mtp_top_checker (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fwdRunPin,
    input wire logic revRunPin,
    input wire logic runFwd,
    input wire logic runRev,
    input wire logic stopCmd,
    input wire logic relayContactA,
    input wire logic relayContactB,
    input wire logic faultRelay
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_prealarm_fault_off: assert property (faultRelay |-> !relayContactA && !relayContactB)
        else $error("relay pre-alarm on during a fault");
    a_fault_stops: assert property (faultRelay |-> stopCmd)
        else $error("fault relay active without stop");
    a_run_exclusive: assert property (!(runFwd && runRev))
        else $error("both run directions active");
    a_fwd_cause: assert property ($rose(runFwd) |-> $past(fwdRunPin, 2))
        else $error("forward run without its pin");
    a_rev_cause: assert property ($rose(runRev) |-> $past(revRunPin, 2))
        else $error("reverse run without its pin");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    c_prealarm: cover property ($rose(relayContactA));
    c_fault: cover property ($rose(faultRelay));
    c_reverse: cover property ($rose(runRev));
endmodule
bind mtp_top mtp_top_checker i_chk (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .fwdRunPin, .revRunPin,
    .runFwd, .runRev, .stopCmd, .relayContactA, .relayContactB, .faultRelay);
`default_nettype wire

// ### mtp_motor_model.sv
// Motor with winding thermistor as seen by the protection block
`default_nettype none
module mtp_motor_model #(
    parameter int FREQ = 5000
) (
    input wire logic clock,
    input wire logic [15:0] loadCurrent,
    input wire logic [11:0] windingTemp,
    output logic [15:0] outputCurrent,
    output logic [15:0] outputFreq,
    output logic [11:0] analogInputTwo
);
    timeunit 1ns;
    timeprecision 1ps;
    // Thermistor on a 0 to 10 V voltage input, full scale code 12'hfff
    always @(posedge clock) begin
        outputCurrent <= loadCurrent;
        outputFreq <= FREQ[15:0];
        analogInputTwo <= windingTemp;
    end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench for the motor protection block
`default_nettype none
`include "mtp_defines.vh"
`define CHK(nm, e, s) begin samplesChecked++; if ((s) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", nm, e, s); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 4;
    localparam longint RATED = 1000;
    logic clock, rst_n, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, fwdRunPin, revRunPin, runFwd, runRev, phaseSwap, stopCmd;
    logic relayContactA, relayContactB, faultRelay, motorOverheatAlarm, irq;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, stopMode, r;
    logic [15:0] outputCurrent, outputFreq, load;
    logic [11:0] analogInputTwo, temp;
    int mismatches = 0, samplesChecked = 0, seed, i, cnt;
    longint expc;
    mtp_top #(.MS_CYCLES(MS)) i_dut (.clock, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .outputCurrent, .outputFreq, .analogInputTwo, .fwdRunPin, .revRunPin, .runFwd,
        .runRev, .phaseSwap, .stopCmd, .stopMode, .relayContactA, .relayContactB,
        .faultRelay, .motorOverheatAlarm, .irq);
    mtp_motor_model i_motor (.clock, .loadCurrent(load), .windingTemp(temp), .outputCurrent,
        .outputFreq, .analogInputTwo);
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    task automatic wr(input logic [4:0] a, input logic [31:0] v);
        bit pa, pw;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        pa = 1;
        pw = 1;
        while (pa || pw) begin
            @(posedge clock);
            if (pa && s_axi_awready) begin s_axi_awvalid <= 0; pa = 0; end
            if (pw && s_axi_wready) begin s_axi_wvalid <= 0; pw = 0; end
        end
        do @(posedge clock); while (s_axi_bvalid !== 1);
        r = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do @(posedge clock); while (s_axi_arready !== 1);
        s_axi_arvalid <= 0;
        do @(posedge clock); while (s_axi_rvalid !== 1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    function automatic logic [31:0] cfgw(int p, int a, int f, int rv, int ai, int ry);
        return (p << `MTP_CFG_PROT_LSB) | (a << `MTP_CFG_OHA_LSB) | (f << `MTP_CFG_OHF_LSB)
            | (rv << `MTP_CFG_REV_LSB) | (ai << `MTP_CFG_AIFN_LSB) | (ry << `MTP_CFG_RLYA_LSB);
    endfunction
    // Cycles until the squared-current integrator passes num tenths of the trip level
    function automatic longint olCycles(longint cur, longint num);
        longint th, det, n;
        th = 0;
        n = 0;
        det = RATED * RATED * 310 / 256;
        while (th * 10 < det * num) begin
            th += (cur * cur - th) / 256;
            n++;
        end
        return n * 127 * MS;
    endfunction
    task automatic waitFor(ref logic s, input longint lim);
        cnt = 0;
        while (s !== 1 && cnt < lim) begin @(posedge clock); cnt++; end
    endtask
    task automatic printVerdict;
        $display("comparisons %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clock);
        mismatches++;
        printVerdict;
    end
    initial begin
        seed = 32'h850f;
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {fwdRunPin, revRunPin, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
        ce = 1;
        load = 0;
        temp = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1;
        repeat (2) @(posedge clock);
        rd(`MTP_OFS_RATED); `CHK("rated", `MTP_RATED_RST, d)
        rd(`MTP_OFS_CFG); `CHK("cfg", `MTP_CFG_RST, d)
        rd(`MTP_OFS_TIME); `CHK("time", `MTP_TIME_RST, d)
        rd(`MTP_OFS_IRQ_MASK); `CHK("mask", 32'h0, d)
        rd(5'h02); `CHK("unaligned", `MTP_RESP_SLVERR, r)
        wr(`MTP_OFS_STATUS, 32'hffffffff); `CHK("status wr", `MTP_RESP_OKAY, r)
        rd(`MTP_OFS_STATUS); `CHK("status", 32'h0, d)
        for (i = 0; i < 4; i++) begin
            wr(`MTP_OFS_CFG, cfgw(1, 3, 1, i, 0, 0));
            @(posedge clock) revRunPin <= 1;
            repeat (8) @(posedge clock);
            `CHK("runRev", (i == 0 || i == 2), runRev)
            `CHK("phaseSwap", (i >= 2), phaseSwap)
            revRunPin <= 0;
            fwdRunPin <= 1;
            repeat (8) @(posedge clock);
            `CHK("runFwd", 1, runFwd)
            fwdRunPin <= 0;
            repeat (8) @(posedge clock);
        end
        wr(`MTP_OFS_TIME, 32'h00010001);
        wr(`MTP_OFS_CFG, cfgw(1, 3, 1, 0, `MTP_AI_MOTOR_TEMP, 0));
        temp <= 12'h9ff;
        repeat (3) @(posedge clock);
        `CHK("filtered", 0, motorOverheatAlarm)
        waitFor(motorOverheatAlarm, 4000); `CHK("filter out", 1, motorOverheatAlarm)
        wr(`MTP_OFS_TIME, 32'h00000001);
        for (i = 0; i < 4; i++) begin
            wr(`MTP_OFS_CFG, cfgw(1, i, 1, 0, `MTP_AI_MOTOR_TEMP, 0));
            temp <= 12'h801 + 12'($unsigned($random(seed)) % 32'h1ff);
            repeat (10) @(posedge clock);
            `CHK("alarm", 1, motorOverheatAlarm)
            `CHK("alarm stop", (i != 3), stopCmd)
            if (i != 3) `CHK("alarm mode", i, stopMode)
            temp <= 12'($unsigned($random(seed)) % 32'h7ff);
            repeat (10) @(posedge clock);
            `CHK("alarm off", 0, motorOverheatAlarm)
        end
        wr(`MTP_OFS_CFG, cfgw(1, 3, 1, 0, 0, 0));
        temp <= 12'hc00;
        repeat (10) @(posedge clock);
        `CHK("other fn", 0, motorOverheatAlarm | faultRelay)
        wr(`MTP_OFS_CFG, cfgw(1, 3, 1, 0, `MTP_AI_MOTOR_TEMP, 0));
        repeat (10) @(posedge clock);
        `CHK("oh fault", 1, faultRelay)
        `CHK("oh mode", `MTP_STOP_COAST, stopMode)
        temp <= 0;
        repeat (10) @(posedge clock);
        `CHK("latched", 1, faultRelay)
        wr(`MTP_OFS_FAULT_CLR, 32'h1);
        repeat (4) @(posedge clock);
        `CHK("cleared", 0, faultRelay)
        wr(`MTP_OFS_IRQ_MASK, 32'h3);
        wr(`MTP_OFS_IRQ_STAT, 32'hf);
        wr(`MTP_OFS_CFG, cfgw(2, 3, 1, 0, 0, `MTP_FN_PREALARM));
        load <= 16'd2000;
        expc = olCycles(2000, 9);
        waitFor(relayContactA, expc * 12 / 10 + 2000);
        `CHK("prealarm", 1, relayContactA)
        `CHK("prealarm time", 1, cnt > expc * 8 / 10)
        `CHK("relay b", 0, relayContactB)
        `CHK("irq pre", 1, irq)
        wr(`MTP_OFS_IRQ_STAT, 32'h2);
        rd(`MTP_OFS_IRQ_STAT); `CHK("pre cleared", 0, d[`MTP_IRQ_PRE])
        expc = olCycles(2000, 10) - expc;
        waitFor(faultRelay, expc * 12 / 10 + 2000);
        `CHK("ol fault", 1, faultRelay)
        `CHK("pre off", 0, relayContactA)
        `CHK("ol mode", `MTP_STOP_COAST, stopMode)
        rd(`MTP_OFS_STATUS); `CHK("ol status", 1, d[0])
        wr(`MTP_OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clock);
        `CHK("irq masked", 0, irq)
        wr(`MTP_OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clock);
        `CHK("irq fault", 1, irq)
        wr(`MTP_OFS_FAULT_CLR, 32'h1);
        repeat (4) @(posedge clock);
        `CHK("trip held", 1, faultRelay)
        wr(`MTP_OFS_CFG, cfgw(0, 3, 1, 0, 0, 0));
        wr(`MTP_OFS_FAULT_CLR, 32'h1);
        rd(`MTP_OFS_STATUS); `CHK("prot off", 32'h0, d)
        load <= 0;
        rst_n <= 0;
        repeat (3) @(posedge clock);
        rst_n <= 1;
        repeat (2) @(posedge clock);
        rd(`MTP_OFS_STATUS); `CHK("power cycle", 32'h0, d)
        printVerdict;
    end
endmodule
`default_nettype wire
